// ===== src/monitor_status_defs.vh
// Purpose: Offsets, bit positions and reset values of the two monitor status registers.
// Assumes: Included by bare name from the status register bank; the bench uses literal offsets.
// Notes: Definitions only.
`ifndef MONITOR_STATUS_DEFS_VH
`define MONITOR_STATUS_DEFS_VH

// Register offsets on the management register port
`define FAN_LIMIT_FLAGS_ADDR 8'h22
`define TEMP_EVENT_FLAGS_ADDR 8'h23

// Power-on values and the unmapped read value
`define FAN_LIMIT_FLAGS_RESET 8'h00
`define TEMP_EVENT_FLAGS_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00

// Field positions in temp_event_flags
`define INT_TEMP_BIT 0
`define BATTERY_BIT 1
`define ANALOG_IN_EIGHT_BIT 2
`define THERMAL_EVENT_BIT 3
`define FAN_CONTROL_EVENT_BIT 4
`define UNUSED_BIT 5
`define INTRUSION_BIT 6
`define GENERAL_PIN_SIXTEEN_BIT 7

`endif

// ===== src/sync_two_flop.v
// Purpose: Two-flop synchroniser for one asynchronous pin level.
// Assumes: Pin changes no faster than a few clock periods.
// Notes: Only the second flop may be read by other logic.
`timescale 1ns/1ps
module sync_two_flop (
    input wire clk_i,
    input wire rstn_i,
    input wire async_i,
    output reg sync_o
);
    reg meta_q;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // sync_two_flop

// ===== src/monitor_status_flags_3_4.v
// Purpose: Fan limit flags and temperature/event flags of a system hardware monitor.
// Assumes: Comparators, conversion sequencer, thermal and fan control logic run on clk_i
//          and hand in per-channel results and one-cycle event pulses.
// Notes: Registers are reached over the internal register port behind the
//        management bus slave; a read answers one cycle later.
//        Event bits 3 and 4 and the event part of bit 0 clear on a read of the second register;
//        an event in the same cycle as that read wins, so none is lost.
//
// How it works
// - Both register images reset to all zeros; fan flags and bits 1-2 stay zero until a conversion completes.
// - Fan bit n is fan n's over-high-limit result of the last conversion.
// - Bits 0-2 show out-of-window results of the last conversion.
// - Internal temperature flag also sets when internal thermal mode engages.
// - Internal temperature flag also sets when internal thermal mode disengages.
// - Thermal-event flag sets when thermal mode engages on any channel.
// - Thermal-event flag sets when thermal mode disengages on any channel.
// - Fan-control event flag sets when automatic control turns the fan on.
// - Fan-control event flag sets when the fan turns off under automatic control.
// - Bit 5 of the second register always reads zero.
// - Bit 6 latches an intrusion event until explicitly cleared.
// - As input, bit 7 reads one while pin sixteen is asserted.
// - As output, written bit 7 drives pin sixteen asserted, polarity configurable.
// - Bit 7 is writable only while pin sixteen is an output.
`timescale 1ns/1ps
`include "monitor_status_defs.vh"

module monitor_status_flags_3_4 #(
    parameter FAN_COUNT = 8,
    parameter ADDR_WIDTH = 8
) (
    input wire clk_i,
    input wire rstn_i,
    // Register port
    input wire [ADDR_WIDTH-1:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // Conversion results, same clock
    input wire conv_done_i,
    input wire [FAN_COUNT-1:0] fan_over_high_i,
    input wire int_temp_out_i,
    input wire battery_out_i,
    input wire analog_in_eight_out_i,
    // Thermal and fan control event pulses, same clock
    input wire int_thermal_engage_i,
    input wire int_thermal_release_i,
    input wire any_thermal_engage_i,
    input wire any_thermal_release_i,
    input wire automatic_fan_control_i,
    input wire fan_turn_on_i,
    input wire fan_turn_off_i,
    // Chassis intrusion
    input wire intrusion_pin_i,
    input wire intrusion_clear_i,
    // General pin sixteen and its configuration
    input wire general_pin_sixteen_i,
    input wire pin_sixteen_is_output_i,
    input wire pin_sixteen_active_high_i,
    output reg general_pin_sixteen_o,
    output reg general_pin_sixteen_oe_n_o,
    // Register images for the rest of the monitor
    output reg [7:0] fan_limit_flags_o,
    output reg [7:0] temp_event_flags_o
);

    // Conversion-cycle result flags
    reg [FAN_COUNT-1:0] fan_flags_q;
    reg [FAN_COUNT-1:0] fan_flags_d;
    reg [2:0] window_flags_q;
    reg [2:0] window_flags_d;

    // One-shot event flags, cleared by reading the register
    reg int_event_q;
    reg int_event_d;
    reg thermal_event_flag_q;
    reg thermal_event_flag_d;
    reg fan_control_event_flag_q;
    reg fan_control_event_flag_d;

    // Intrusion latch and pin sixteen state
    reg intrusion_flag_q;
    reg intrusion_flag_d;
    reg pin_bit_q;
    reg pin_bit_d;

    wire intrusion_sync;
    wire pin_sixteen_sync;

    // Decoded accesses
    wire wr_temp_reg;
    wire rd_temp_reg;
    wire rd_fan_reg;

    // Assembled register views
    reg [7:0] fan_view;
    reg [7:0] temp_view;
    reg general_pin_sixteen_bit;
    reg [7:0] rdata_d;
    reg drive_level_d;

    sync_two_flop u_sync_intrusion (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(intrusion_pin_i),
        .sync_o(intrusion_sync)
    );

    sync_two_flop u_sync_pin_sixteen (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(general_pin_sixteen_i),
        .sync_o(pin_sixteen_sync)
    );

    // Offsets sized to the port so the decode compares equal widths
    localparam [ADDR_WIDTH-1:0] FAN_ADDR = `FAN_LIMIT_FLAGS_ADDR;
    localparam [ADDR_WIDTH-1:0] TEMP_ADDR = `TEMP_EVENT_FLAGS_ADDR;

    assign wr_temp_reg = reg_wr_i && (reg_addr_i == TEMP_ADDR);
    assign rd_temp_reg = reg_rd_i && (reg_addr_i == TEMP_ADDR);
    assign rd_fan_reg = reg_rd_i && (reg_addr_i == FAN_ADDR);

    // Limit results are refreshed only at the end of a conversion cycle
    always @* begin
        fan_flags_d = fan_flags_q;
        window_flags_d = window_flags_q;
        if (conv_done_i) begin
            fan_flags_d = fan_over_high_i;
            window_flags_d = {analog_in_eight_out_i, battery_out_i, int_temp_out_i};
        end
    end

    // Event flags: a set in the same cycle as the clearing read wins,
    // so an event is never lost to a read racing it.
    always @* begin
        int_event_d = int_event_q;
        if (rd_temp_reg) begin
            int_event_d = 1'b0;
        end
        if (int_thermal_engage_i) begin
            int_event_d = 1'b1;
        end
        if (int_thermal_release_i) begin
            int_event_d = 1'b1;
        end
    end

    always @* begin
        thermal_event_flag_d = thermal_event_flag_q;
        if (rd_temp_reg) begin
            thermal_event_flag_d = 1'b0;
        end
        if (any_thermal_engage_i) begin
            thermal_event_flag_d = 1'b1;
        end
        if (any_thermal_release_i) begin
            thermal_event_flag_d = 1'b1;
        end
    end

    // Fan events count only while automatic control owns the fan
    always @* begin
        fan_control_event_flag_d = fan_control_event_flag_q;
        if (rd_temp_reg) begin
            fan_control_event_flag_d = 1'b0;
        end
        if (automatic_fan_control_i && fan_turn_on_i) begin
            fan_control_event_flag_d = 1'b1;
        end
        if (automatic_fan_control_i && fan_turn_off_i) begin
            fan_control_event_flag_d = 1'b1;
        end
    end

    // Intrusion stays recorded after the pin goes quiet; set beats clear
    always @* begin
        intrusion_flag_d = intrusion_flag_q;
        if (intrusion_clear_i) begin
            intrusion_flag_d = 1'b0;
        end
        if (intrusion_sync) begin
            intrusion_flag_d = 1'b1;
        end
    end

    // Pin sixteen: host data only lands while the pin is an output
    always @* begin
        pin_bit_d = pin_bit_q;
        if (wr_temp_reg && pin_sixteen_is_output_i) begin
            pin_bit_d = reg_wdata_i[`GENERAL_PIN_SIXTEEN_BIT];
        end
    end

    // Asserted level of the pin follows the polarity setting
    always @* begin
        if (pin_sixteen_is_output_i) begin
            general_pin_sixteen_bit = pin_bit_q;
        end else if (pin_sixteen_active_high_i) begin
            general_pin_sixteen_bit = pin_sixteen_sync;
        end else begin
            general_pin_sixteen_bit = ~pin_sixteen_sync;
        end
    end

    // Drive follows the next stored bit so the pin moves with the write
    always @* begin
        if (pin_sixteen_active_high_i) begin
            drive_level_d = pin_bit_d;
        end else begin
            drive_level_d = ~pin_bit_d;
        end
    end

    // Register views; all other write data is dropped
    always @* begin
        fan_view = 8'h00;
        fan_view[FAN_COUNT-1:0] = fan_flags_q;
        temp_view = `TEMP_EVENT_FLAGS_RESET;
        temp_view[`INT_TEMP_BIT] = window_flags_q[0] | int_event_q;
        temp_view[`BATTERY_BIT] = window_flags_q[1];
        temp_view[`ANALOG_IN_EIGHT_BIT] = window_flags_q[2];
        temp_view[`THERMAL_EVENT_BIT] = thermal_event_flag_q;
        temp_view[`FAN_CONTROL_EVENT_BIT] = fan_control_event_flag_q;
        temp_view[`UNUSED_BIT] = 1'b0;
        temp_view[`INTRUSION_BIT] = intrusion_flag_q;
        temp_view[`GENERAL_PIN_SIXTEEN_BIT] = general_pin_sixteen_bit;
    end

    // Read data; unmapped offsets answer zero
    always @* begin
        if (rd_fan_reg) begin
            rdata_d = fan_view;
        end else if (rd_temp_reg) begin
            rdata_d = temp_view;
        end else if (reg_rd_i) begin
            rdata_d = `UNMAPPED_READ_VALUE;
        end else begin
            rdata_d = reg_rdata_o;
        end
    end

    // Conversion results; status bits take no write data at all
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            fan_flags_q <= {FAN_COUNT{1'b0}};
            window_flags_q <= 3'h0;
        end else begin
            fan_flags_q <= fan_flags_d;
            window_flags_q <= window_flags_d;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            int_event_q <= 1'b0;
            thermal_event_flag_q <= 1'b0;
            fan_control_event_flag_q <= 1'b0;
        end else begin
            int_event_q <= int_event_d;
            thermal_event_flag_q <= thermal_event_flag_d;
            fan_control_event_flag_q <= fan_control_event_flag_d;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            intrusion_flag_q <= 1'b0;
            pin_bit_q <= 1'b0;
        end else begin
            intrusion_flag_q <= intrusion_flag_d;
            pin_bit_q <= pin_bit_d;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= rdata_d;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // Pin floats until configured as an output
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            general_pin_sixteen_o <= 1'b0;
            general_pin_sixteen_oe_n_o <= 1'b1;
        end else begin
            general_pin_sixteen_o <= drive_level_d;
            general_pin_sixteen_oe_n_o <= ~pin_sixteen_is_output_i;
        end
    end

    // Images lag the stored state by one cycle
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            fan_limit_flags_o <= `FAN_LIMIT_FLAGS_RESET;
            temp_event_flags_o <= `TEMP_EVENT_FLAGS_RESET;
        end else begin
            fan_limit_flags_o <= fan_view;
            temp_event_flags_o <= temp_view;
        end
    end

endmodule // monitor_status_flags_3_4

// ===== tb/status_flags_sva.sv
// Purpose: Port-level checks of the monitor status flag bank.
// Assumes: Bound to monitor_status_flags_3_4 from tb; one clock domain.
// Notes: Register images lag the stored state by one cycle.
`timescale 1ns/1ps
module status_flags_sva #(
    parameter FAN_COUNT = 8
) (
    input wire clk_i, input wire rstn_i,
    input wire [7:0] reg_addr_i, input wire reg_wr_i, input wire reg_rd_i,
    input wire [7:0] reg_wdata_i, input wire [7:0] reg_rdata_o, input wire reg_rvalid_o,
    input wire conv_done_i, input wire [FAN_COUNT-1:0] fan_over_high_i,
    input wire int_thermal_engage_i, input wire int_thermal_release_i,
    input wire any_thermal_engage_i, input wire any_thermal_release_i,
    input wire automatic_fan_control_i, input wire fan_turn_on_i, input wire fan_turn_off_i,
    input wire intrusion_clear_i, input wire general_pin_sixteen_i,
    input wire pin_sixteen_is_output_i, input wire pin_sixteen_active_high_i,
    input wire general_pin_sixteen_o, input wire general_pin_sixteen_oe_n_o,
    input wire [7:0] fan_limit_flags_o, input wire [7:0] temp_event_flags_o
);
    wire wd7 = reg_wdata_i[7];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_pin_wr;
        reg_wr_i && reg_addr_i == 8'h23 && pin_sixteen_is_output_i
            ##1 pin_sixteen_is_output_i && !reg_wr_i;
    endsequence
    sequence s_pin_steady;
        (!pin_sixteen_is_output_i && $stable(general_pin_sixteen_i)
            && $stable(pin_sixteen_active_high_i)) [*5];
    endsequence
    sequence s_kept;
        !intrusion_clear_i ##1 temp_event_flags_o[6];
    endsequence
    chk_reset_zero: assert property ($rose(rstn_i) |->
        fan_limit_flags_o == 8'h00 && temp_event_flags_o == 8'h00) else $error("reset image");
    chk_read_data: assert property (reg_rd_i |=> reg_rvalid_o && reg_rdata_o ==
        ($past(reg_addr_i) == 8'h22 ? fan_limit_flags_o :
        $past(reg_addr_i) == 8'h23 ? temp_event_flags_o : 8'h00)) else $error("read data");
    chk_valid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("stray valid");
    chk_fan_take: assert property (conv_done_i |-> ##2
        fan_limit_flags_o == $past(fan_over_high_i, 2)) else $error("fan take");
    chk_fan_hold: assert property (!conv_done_i |-> ##2
        fan_limit_flags_o == $past(fan_limit_flags_o)) else $error("fan hold");
    chk_bit_five: assert property (!temp_event_flags_o[5])
        else $error("bit five");
    chk_int_event: assert property (int_thermal_engage_i || int_thermal_release_i
        |-> ##2 temp_event_flags_o[0]) else $error("int event");
    chk_thermal_mode_event: assert property (any_thermal_engage_i || any_thermal_release_i
        |-> ##2 temp_event_flags_o[3]) else $error("thermal event");
    chk_fan_event: assert property (automatic_fan_control_i &&
        (fan_turn_on_i || fan_turn_off_i) |-> ##2 temp_event_flags_o[4]) else $error("fan event");
    chk_intrusion_kept: assert property (s_kept |=> temp_event_flags_o[6])
        else $error("intrusion lost");
    chk_pin_drive: assert property (s_pin_wr |-> !general_pin_sixteen_oe_n_o &&
        general_pin_sixteen_o == ($past(wd7) ~^ pin_sixteen_active_high_i)) else $error("drive");
    chk_pin_input: assert property (s_pin_steady |-> temp_event_flags_o[7] ==
        (general_pin_sixteen_i ~^ pin_sixteen_active_high_i)) else $error("pin input");
endmodule // status_flags_sva

// ===== tb/mgmt_host_model.sv
// Purpose: Management host issuing single-byte register accesses.
// Assumes: Strobes change 1 ns after a rising edge, held one cycle.
// Notes: Idle address and data show inverted values, never stale ones.
`timescale 1ns/1ps
module mgmt_host_model (
    input wire clk_i,
    output logic [7:0] reg_addr_o = 8'h00,
    output logic [7:0] reg_wdata_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0
);
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = w;
        reg_rd_o = !w;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
endmodule // mgmt_host_model

// ===== tb/tb.sv
// Purpose: Self-checking bench of the monitor status flag bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Reads queue their expected byte; a negedge monitor compares.
`timescale 1ns/1ps
module tb;
    logic clk_i = 0, rstn_i = 0, conv_done_i = 0, int_temp_out_i = 0, battery_out_i = 0;
    logic analog_in_eight_out_i = 0, automatic_fan_control_i = 1, intrusion_pin_i = 0;
    logic intrusion_clear_i = 0, general_pin_sixteen_i = 0, pin_sixteen_is_output_i = 0;
    logic pin_sixteen_active_high_i = 1;
    logic [7:0] fan_over_high_i = 8'h00, v, q[$];
    logic [5:0] ev = 6'h00;
    logic [7:0] evx [0:6] = '{8'h01, 8'h01, 8'h08, 8'h08, 8'h10, 8'h10, 8'h00};
    wire int_thermal_engage_i = ev[0], int_thermal_release_i = ev[1];
    wire any_thermal_engage_i = ev[2], any_thermal_release_i = ev[3];
    wire fan_turn_on_i = ev[4], fan_turn_off_i = ev[5];
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, fan_limit_flags_o, temp_event_flags_o;
    wire reg_wr_i, reg_rd_i, reg_rvalid_o, general_pin_sixteen_o, general_pin_sixteen_oe_n_o;
    integer seed = 39884, mismatches = 0, compares = 0, i, j;
    always #50 clk_i = ~clk_i;
    mgmt_host_model i_host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
    monitor_status_flags_3_4 #(.FAN_COUNT(8), .ADDR_WIDTH(8)) i_dut (.*);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        q.push_back(exp);
        i_host.access(1'b0, a, 8'h00);
        for (int k = 0; k < 4 && q.size() > 0; k++) @(negedge clk_i);
        if (q.size() > 0) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic conv(input logic [7:0] f, input logic [2:0] w);
        @(posedge clk_i);
        #1 {conv_done_i, fan_over_high_i} = {1'b1, f};
        {analog_in_eight_out_i, battery_out_i, int_temp_out_i} = w;
        @(posedge clk_i);
        #1 {conv_done_i, fan_over_high_i} = {1'b0, ~f};
        // Changed results without a strobe must not reach the flags
        {analog_in_eight_out_i, battery_out_i, int_temp_out_i} = ~w;
    endtask
    always @(negedge clk_i) if (reg_rvalid_o === 1'b1) begin
        if (q.size() == 0) begin
            mismatches++;
            $display("[ERR] %0t read answer without request", $time);
        end else check(reg_rdata_o, q.pop_front());
    end
    initial begin
        repeat (6) @(posedge clk_i);
        #1 rstn_i = 1;
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        rd(8'h40, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            conv(v, v[7:5]);
            i_host.access(1'b1, 8'h22, ~v);
            i_host.access(1'b1, 8'h23, 8'hFF);
            rd(8'h22, v);
            rd(8'h23, {5'h00, v[7:5]});
            check(fan_limit_flags_o, v);
            check(temp_event_flags_o, {5'h00, v[7:5]});
        end
        conv(8'h00, 3'h0);
        for (j = 0; j < 7; j++) begin
            @(posedge clk_i);
            #1 automatic_fan_control_i = (j != 6);
            ev = (j == 6) ? 6'h10 : 6'h01 << j;
            @(posedge clk_i);
            #1 ev = 6'h00;
            rd(8'h23, evx[j]);
            rd(8'h23, 8'h00);
        end
        @(posedge clk_i);
        #1 intrusion_pin_i = 1;
        repeat (4) @(posedge clk_i);
        #1 intrusion_pin_i = 0;
        repeat (4) @(posedge clk_i);
        rd(8'h23, 8'h40);
        rd(8'h23, 8'h40);
        @(posedge clk_i);
        #1 intrusion_clear_i = 1;
        @(posedge clk_i);
        #1 intrusion_clear_i = 0;
        rd(8'h23, 8'h00);
        for (j = 0; j < 4; j++) begin
            @(posedge clk_i);
            #1 {pin_sixteen_active_high_i, general_pin_sixteen_i} = j[1:0];
            repeat (5) @(posedge clk_i);
            i_host.access(1'b1, 8'h23, {j[1] ^ j[0], 7'h7F});
            rd(8'h23, {j[1] ~^ j[0], 7'h00});
        end
        for (j = 0; j < 4; j++) begin
            @(posedge clk_i);
            #1 {pin_sixteen_is_output_i, pin_sixteen_active_high_i} = {1'b1, j[1]};
            i_host.access(1'b1, 8'h23, {j[0], 7'h00});
            rd(8'h23, {j[0], 7'h00});
            check({6'h00, general_pin_sixteen_oe_n_o, general_pin_sixteen_o},
                {7'h00, j[0] ~^ j[1]});
        end
        conv(8'hA5, 3'h7);
        rd(8'h22, 8'hA5);
        @(posedge clk_i);
        #1 rstn_i = 0;
        repeat (3) @(posedge clk_i);
        #1 rstn_i = 1;
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        conclude();
    end
endmodule // tb
bind monitor_status_flags_3_4 status_flags_sva #(.FAN_COUNT(FAN_COUNT)) i_sva (.*);
